// File: stop_sel_pkg.sv
// Purpose: shared constants and types for the stop-method selector and overload monitor
// Assumes: single 125 MHz clock domain, synchronous active-low reset
// Notes:   digit widths and percentage scale are shared by both design files
package stop_sel_pkg;

	// ==========================================================
	// clock and configuration defaults
	// ==========================================================
	localparam int          CLK_MHZ            = 125;
	localparam logic [3:0]  SERVO_OFF_DEFAULT  = 4'h0;
	localparam logic [3:0]  G2_STOP_DEFAULT    = 4'h0;
	localparam logic [3:0]  G2_MODE_DEFAULT    = 4'h0;
	localparam logic [7:0]  WARN_PCT_DEFAULT   = 8'h14;
	localparam logic [7:0]  DERATE_PCT_DEFAULT = 8'h64;
	localparam logic [7:0]  PCT_FULL           = 8'h64;

	// ==========================================================
	// digit encodings
	// ==========================================================
	localparam logic [3:0]  SO_BRAKE_HOLD      = 4'h0;
	localparam logic [3:0]  SO_BRAKE_FREE      = 4'h1;
	localparam logic [3:0]  SO_FREE_FREE       = 4'h2;
	localparam logic [3:0]  G2M_ZERO_SPEED     = 4'h0;
	localparam logic [3:0]  G2M_AS_GROUP1      = 4'h1;
	localparam logic [3:0]  G2M_BY_STOP_DIGIT  = 4'h2;
	localparam logic [3:0]  G2S_TORQUE_HOLD    = 4'h1;
	localparam logic [3:0]  G2S_TORQUE_FREE    = 4'h2;
	localparam logic [3:0]  G2S_TIME_HOLD      = 4'h3;
	localparam logic [3:0]  G2S_TIME_FREE      = 4'h4;

	// control mode indication
	localparam logic [1:0]  MODE_POSITION      = 2'h0;
	localparam logic [1:0]  MODE_SPEED         = 2'h1;
	localparam logic [1:0]  MODE_TORQUE        = 2'h2;

	// ==========================================================
	// overload detection counts
	// ==========================================================
	localparam int          CONT_LIMIT_DEFAULT = 100000;
	localparam logic [3:0]  INST_FACTOR        = 4'h3;

	typedef enum {
		sm_brake,
		sm_free,
		sm_zero_speed,
		sm_torque_decel,
		sm_time_decel
	} stop_method_t;

	typedef enum {
		fs_brake,
		fs_free
	} final_state_t;

	typedef struct packed {
		logic [2:0] method;
		logic       hold_brake;
	} stop_plan_t;

endpackage

// File: overload_monitor.sv
// Purpose: overload warning, continuous and instantaneous overload alarm detection
// Assumes: load and rated current share one unsigned scale
// Notes:   derating is sampled by the parent; warning percent acts at once
`timescale 1ns/1ns
module overload_monitor #(
	parameter int CUR_W      = 16,
	parameter int ACC_W      = 20,
	parameter int CONT_LIMIT = stop_sel_pkg::CONT_LIMIT_DEFAULT
) (
	input  wire logic             clk,
	input  wire logic             nrst,
	input  wire logic [CUR_W-1:0] load_current,
	input  wire logic [CUR_W-1:0] rated_current,
	input  wire logic [7:0]       warn_pct,
	input  wire logic [7:0]       derate_pct,
	output logic                  overload_warning,
	output logic                  overload_alarm_cont,
	output logic                  overload_alarm_inst
);
	localparam int PROD_W = CUR_W + 8;
	localparam int WIDE_W = ACC_W + 8;

	if (CONT_LIMIT < 1 || CONT_LIMIT >= (2 ** ACC_W)) begin : g_chk
		$error("overload limit does not fit the accumulator");
	end

	logic [ACC_W-1:0]  acc;
	logic [ACC_W-1:0]  next_acc;
	logic              next_warning;
	logic              next_cont;
	logic              next_inst;
	logic [PROD_W-1:0] load_scaled;
	logic [PROD_W-1:0] base_scaled;
	logic [7:0]        warn_clip;
	logic [ACC_W-1:0]  limit;

	// ==========================================================
	// thermal accumulator
	// ==========================================================
	// compare in percent units to avoid a divider
	always_comb begin
		limit       = ACC_W'(CONT_LIMIT);
		load_scaled = PROD_W'(load_current) * PROD_W'(stop_sel_pkg::PCT_FULL);
		base_scaled = PROD_W'(rated_current) * PROD_W'(derate_pct);
		warn_clip   = (warn_pct > stop_sel_pkg::PCT_FULL) ? stop_sel_pkg::PCT_FULL : warn_pct;
		if (load_scaled > base_scaled) begin
			next_acc = (acc >= limit) ? limit : acc + ACC_W'(1);
		end else begin
			next_acc = (acc == '0) ? acc : acc - ACC_W'(1);
		end
		next_cont    = (acc >= limit);
		next_warning = (acc != '0) &&
			(WIDE_W'(acc) * WIDE_W'(stop_sel_pkg::PCT_FULL) >=
			 WIDE_W'(limit) * WIDE_W'(warn_clip));
		// fixed threshold, no setting reaches it
		next_inst = (PROD_W'(load_current) >=
			PROD_W'(rated_current) * PROD_W'(stop_sel_pkg::INST_FACTOR));
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			acc                 <= '0;
			overload_warning    <= 1'b0;
			overload_alarm_cont <= 1'b0;
			overload_alarm_inst <= 1'b0;
		end else begin
			acc                 <= next_acc;
			overload_warning    <= next_warning;
			overload_alarm_cont <= next_cont;
			overload_alarm_inst <= next_inst;
		end
	end

	property p_inst_fixed;
		@(posedge clk) disable iff (!nrst)
		(load_current >= CUR_W'(3) * rated_current) && (rated_current < 16'h5000) |=>
			overload_alarm_inst;
	endproperty
	a_inst_fixed: assert property (p_inst_fixed) else $error("instantaneous alarm missed");

	property p_cont_at_limit;
		@(posedge clk) disable iff (!nrst)
		(acc >= ACC_W'(CONT_LIMIT)) |=> overload_alarm_cont;
	endproperty
	a_cont_at_limit: assert property (p_cont_at_limit) else $error("continuous alarm missed");

	property p_warn_full;
		@(posedge clk) disable iff (!nrst)
		overload_warning && ($past(warn_pct) >= stop_sel_pkg::PCT_FULL) |->
			$past(acc) >= ACC_W'(CONT_LIMIT);
	endproperty
	a_warn_full: assert property (p_warn_full) else $error("warning earlier than scaled time");
endmodule

// File: servo_stop_select.sv
// Purpose: choose motor stop method and post-stop state on servo off and alarms
// Assumes: alarm and servo-on levels held by their sources; motor speed flags from feedback
// Notes:   stop digits and derating are captured once after reset release
// Notes on behaviour
// - servo off stops per servo-off digit: 0 brake-hold, 1 brake-then-free, 2 free
// - brake gives no torque while motor is stationary or crawling
// - first-group alarm stops using the servo-off digit
// - second-group alarm stop comes from three digits combined
// - group2 mode 0: zero-speed stop, then brake if servo-off digit 0
// - group2 mode 1: handled exactly like a first-group alarm
// - group2 mode 2, stop 1/2: torque-limited decel, then brake or free
// - group2 mode 2, stop 3/4: timed decel, then brake or free
// - in torque control group2 stop digit ignored, servo-off digit followed
// - warning and continuous alarm adjustable, instantaneous alarm fixed
// - warning time scales with warning percent, effective immediately
// - continuous alarm base current reduced by derating, effective after restart
// - lower derating raises continuous alarm earlier
// - brake shorts the windings; zero-speed stop forces speed command zero
`timescale 1ns/1ns
module servo_stop_select #(
	parameter int CUR_W      = 16,
	parameter int ACC_W      = 20,
	parameter int CONT_LIMIT = stop_sel_pkg::CONT_LIMIT_DEFAULT
) (
	input  wire logic             clk,
	input  wire logic             nrst,
	input  wire logic [3:0]       servo_off_stop_select,
	input  wire logic [3:0]       group2_stop_select,
	input  wire logic [3:0]       group2_mode_select,
	input  wire logic [1:0]       control_mode,
	input  wire logic             servo_on,
	input  wire logic             first_group_alarm,
	input  wire logic             second_group_alarm,
	input  wire logic             motor_stopped,
	input  wire logic             motor_slow,
	input  wire logic [15:0]      emergency_stop_torque,
	input  wire logic [15:0]      deceleration_time_setting,
	input  wire logic [7:0]       overload_warning_percent,
	input  wire logic [7:0]       overload_base_current_derating,
	input  wire logic [CUR_W-1:0] load_current,
	input  wire logic [CUR_W-1:0] rated_current,
	output logic                  power_stage_on,
	output logic                  winding_short_brake,
	output logic                  brake_torque_active,
	output logic                  zero_speed_cmd,
	output logic                  torque_limit_decel,
	output logic                  time_decel,
	output logic [15:0]           decel_torque_limit,
	output logic [15:0]           decel_time,
	output logic                  overload_warning,
	output logic                  overload_alarm_cont,
	output logic                  overload_alarm_inst
);
	typedef enum {
		st_run,
		st_stopping,
		st_stopped
	} stop_state_t;

	// ==========================================================
	// plan decoding
	// ==========================================================
	function automatic stop_sel_pkg::stop_plan_t group1_plan(input logic [3:0] so);
		stop_sel_pkg::stop_plan_t p;
		p.method     = 3'(stop_sel_pkg::sm_brake);
		p.hold_brake = 1'b1;
		case (so)
			stop_sel_pkg::SO_BRAKE_FREE: begin
				p.hold_brake = 1'b0;
			end
			stop_sel_pkg::SO_FREE_FREE: begin
				p.method     = 3'(stop_sel_pkg::sm_free);
				p.hold_brake = 1'b0;
			end
			default: begin
				p.hold_brake = 1'b1;
			end
		endcase
		return p;
	endfunction

	function automatic stop_sel_pkg::stop_plan_t group2_plan(
		input logic [3:0] so,
		input logic [3:0] g2s,
		input logic [3:0] g2m,
		input logic       torque_ctl
	);
		stop_sel_pkg::stop_plan_t p;
		logic                     hold;
		hold = (so == stop_sel_pkg::SO_BRAKE_HOLD);
		p    = group1_plan(so);
		if (torque_ctl) begin
			p = group1_plan(so);
		end else begin
			case (g2m)
				stop_sel_pkg::G2M_ZERO_SPEED: begin
					p.method     = 3'(stop_sel_pkg::sm_zero_speed);
					p.hold_brake = hold;
				end
				stop_sel_pkg::G2M_AS_GROUP1: begin
					p = group1_plan(so);
				end
				stop_sel_pkg::G2M_BY_STOP_DIGIT: begin
					case (g2s)
						stop_sel_pkg::G2S_TORQUE_HOLD: begin
							p.method     = 3'(stop_sel_pkg::sm_torque_decel);
							p.hold_brake = hold;
						end
						stop_sel_pkg::G2S_TORQUE_FREE: begin
							p.method     = 3'(stop_sel_pkg::sm_torque_decel);
							p.hold_brake = 1'b0;
						end
						stop_sel_pkg::G2S_TIME_HOLD: begin
							p.method     = 3'(stop_sel_pkg::sm_time_decel);
							p.hold_brake = hold;
						end
						stop_sel_pkg::G2S_TIME_FREE: begin
							p.method     = 3'(stop_sel_pkg::sm_time_decel);
							p.hold_brake = 1'b0;
						end
						default: begin
							p = group1_plan(so);
						end
					endcase
				end
				default: begin
					p = group1_plan(so);
				end
			endcase
		end
		return p;
	endfunction

	// ==========================================================
	// power-up capture of configuration
	// ==========================================================
	logic                     cfg_valid;
	logic [3:0]               so_l;
	logic [3:0]               g2s_l;
	logic [3:0]               g2m_l;
	logic [7:0]               derate_l;

	// later edits of stop digits and derating must not change behaviour until restart
	always_ff @(posedge clk) begin
		if (!nrst) begin
			cfg_valid <= 1'b0;
			so_l      <= stop_sel_pkg::SERVO_OFF_DEFAULT;
			g2s_l     <= stop_sel_pkg::G2_STOP_DEFAULT;
			g2m_l     <= stop_sel_pkg::G2_MODE_DEFAULT;
			derate_l  <= stop_sel_pkg::DERATE_PCT_DEFAULT;
		end else if (!cfg_valid) begin
			cfg_valid <= 1'b1;
			so_l      <= servo_off_stop_select;
			g2s_l     <= group2_stop_select;
			g2m_l     <= group2_mode_select;
			derate_l  <= overload_base_current_derating;
		end
	end

	// ==========================================================
	// stop sequencer
	// ==========================================================
	stop_state_t              state;
	stop_state_t              next_state;
	stop_sel_pkg::stop_plan_t plan;
	stop_sel_pkg::stop_plan_t next_plan;
	logic                     from_g2;
	logic                     next_from_g2;
	logic                     torque_ctl;
	logic                     next_power;
	logic                     next_brake;
	logic                     next_zero;
	logic                     next_tq;
	logic                     next_tm;

	assign torque_ctl = (control_mode == stop_sel_pkg::MODE_TORQUE);

	always_comb begin
		next_state   = state;
		next_plan    = plan;
		next_from_g2 = from_g2;
		case (state)
			st_run: begin
				if (first_group_alarm || !servo_on) begin
					next_state   = st_stopping;
					next_plan    = group1_plan(so_l);
					next_from_g2 = 1'b0;
				end else if (second_group_alarm) begin
					next_state   = st_stopping;
					next_plan    = group2_plan(so_l, g2s_l, g2m_l, torque_ctl);
					next_from_g2 = 1'b1;
				end
			end
			st_stopping: begin
				// a first-group alarm overrides a gentler group2 stop
				if (first_group_alarm && from_g2) begin
					next_plan    = group1_plan(so_l);
					next_from_g2 = 1'b0;
				end
				if (motor_stopped) begin
					next_state = st_stopped;
				end
			end
			st_stopped: begin
				if (cfg_valid && servo_on && !first_group_alarm && !second_group_alarm) begin
					next_state = st_run;
				end
			end
			default: begin
				next_state = st_stopped;
			end
		endcase

		next_power = 1'b0;
		next_brake = 1'b0;
		next_zero  = 1'b0;
		next_tq    = 1'b0;
		next_tm    = 1'b0;
		case (next_state)
			st_run: begin
				next_power = 1'b1;
			end
			st_stopping: begin
				case (next_plan.method)
					3'(stop_sel_pkg::sm_brake): begin
						next_brake = 1'b1;
					end
					3'(stop_sel_pkg::sm_zero_speed): begin
						next_power = 1'b1;
						next_zero  = 1'b1;
					end
					3'(stop_sel_pkg::sm_torque_decel): begin
						next_power = 1'b1;
						next_tq    = 1'b1;
					end
					3'(stop_sel_pkg::sm_time_decel): begin
						next_power = 1'b1;
						next_tm    = 1'b1;
					end
					default: begin
						next_power = 1'b0;
					end
				endcase
			end
			default: begin
				next_brake = next_plan.hold_brake;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			state               <= st_stopped;
			plan                <= '0;
			from_g2             <= 1'b0;
			power_stage_on      <= 1'b0;
			winding_short_brake <= 1'b0;
			brake_torque_active <= 1'b0;
			zero_speed_cmd      <= 1'b0;
			torque_limit_decel  <= 1'b0;
			time_decel          <= 1'b0;
			decel_torque_limit  <= 16'h0000;
			decel_time          <= 16'h0000;
		end else begin
			state               <= next_state;
			plan                <= next_plan;
			from_g2             <= next_from_g2;
			power_stage_on      <= next_power;
			winding_short_brake <= next_brake;
			brake_torque_active <= next_brake && !motor_slow;
			zero_speed_cmd      <= next_zero;
			torque_limit_decel  <= next_tq;
			time_decel          <= next_tm;
			decel_torque_limit  <= next_tq ? emergency_stop_torque : 16'h0000;
			decel_time          <= next_tm ? deceleration_time_setting : 16'h0000;
		end
	end

	// ==========================================================
	// overload detection
	// ==========================================================
	overload_monitor #(
		.CUR_W      (CUR_W),
		.ACC_W      (ACC_W),
		.CONT_LIMIT (CONT_LIMIT)
	) u_overload (
		.clk                 (clk),
		.nrst                (nrst),
		.load_current        (load_current),
		.rated_current       (rated_current),
		.warn_pct            (overload_warning_percent),
		.derate_pct          (derate_l),
		.overload_warning    (overload_warning),
		.overload_alarm_cont (overload_alarm_cont),
		.overload_alarm_inst (overload_alarm_inst)
	);

	// ==========================================================
	// checks
	// ==========================================================
	logic run_ok;
	assign run_ok = (state == st_run);

	property p_off_brake;
		@(posedge clk) disable iff (!nrst)
		run_ok && !servo_on && so_l == 4'h0 |=> winding_short_brake && !power_stage_on;
	endproperty
	a_off_brake: assert property (p_off_brake) else $error("servo off brake missing");

	property p_off_free;
		@(posedge clk) disable iff (!nrst)
		run_ok && !servo_on && so_l == 4'h2 |=> !winding_short_brake && !power_stage_on;
	endproperty
	a_off_free: assert property (p_off_free) else $error("free stop drives motor");

	property p_slow_no_torque;
		@(posedge clk) disable iff (!nrst)
		$past(motor_slow) |-> !brake_torque_active;
	endproperty
	a_slow_no_torque: assert property (p_slow_no_torque) else $error("brake torque at low speed");

	property p_g1_brake;
		@(posedge clk) disable iff (!nrst)
		run_ok && first_group_alarm && so_l == 4'h0 |=> winding_short_brake;
	endproperty
	a_g1_brake: assert property (p_g1_brake) else $error("group1 alarm brake missing");

	property p_g2_zero;
		@(posedge clk) disable iff (!nrst)
		run_ok && servo_on && !first_group_alarm && second_group_alarm && g2m_l == 4'h0
			&& !torque_ctl |=> zero_speed_cmd && power_stage_on;
	endproperty
	a_g2_zero: assert property (p_g2_zero) else $error("zero speed stop missing");

	property p_g2_as_g1;
		@(posedge clk) disable iff (!nrst)
		run_ok && servo_on && !first_group_alarm && second_group_alarm && g2m_l == 4'h1
			&& so_l == 4'h0 |=> winding_short_brake;
	endproperty
	a_g2_as_g1: assert property (p_g2_as_g1) else $error("group2 not as group1");

	property p_torque_decel;
		@(posedge clk) disable iff (!nrst)
		run_ok && servo_on && !first_group_alarm && second_group_alarm && g2m_l == 4'h2
			&& g2s_l == 4'h1 && !torque_ctl |=> torque_limit_decel
			&& decel_torque_limit == $past(emergency_stop_torque);
	endproperty
	a_torque_decel: assert property (p_torque_decel) else $error("torque decel missing");

	property p_time_free;
		@(posedge clk) disable iff (!nrst)
		state == st_stopping && time_decel && motor_stopped && g2s_l == 4'h4
			&& !first_group_alarm |=> state == st_stopped && !winding_short_brake;
	endproperty
	a_time_free: assert property (p_time_free) else $error("timed decel not free after stop");

	property p_torque_mode;
		@(posedge clk) disable iff (!nrst)
		run_ok && servo_on && !first_group_alarm && second_group_alarm && torque_ctl
			&& so_l == 4'h0 |=> winding_short_brake && !torque_limit_decel && !zero_speed_cmd;
	endproperty
	a_torque_mode: assert property (p_torque_mode) else $error("torque control used group2 digit");

	property p_latched;
		@(posedge clk) disable iff (!nrst)
		cfg_valid |=> $stable(so_l) && $stable(g2s_l) && $stable(g2m_l) && $stable(derate_l);
	endproperty
	a_latched: assert property (p_latched) else $error("latched digits changed");
endmodule

// File: motor_model.sv
// Purpose: behavioural motor and power stage on the far side of the stop selector
// Assumes: speed in coarse units, motor at rest after reset
// Notes:   fixed ramps only; no load torque or inertia spread
`timescale 1ns/1ns
module motor_model (
	input  wire logic clk,
	input  wire logic nrst,
	input  wire logic power_stage_on,
	input  wire logic winding_short_brake,
	input  wire logic slowing,
	output logic      motor_stopped,
	output logic      motor_slow
);
	logic [7:0] speed;

	// ==========================================================
	// speed ramp
	// ==========================================================
	// shorted windings stop four times faster than coasting
	always_ff @(posedge clk) begin
		if (!nrst)
			speed <= 8'h00;
		else if (power_stage_on && !slowing)
			speed <= (speed > 8'h26) ? 8'h28 : speed + 8'h02;
		else if (winding_short_brake)
			speed <= (speed > 8'h04) ? speed - 8'h04 : 8'h00;
		else if (speed != 8'h00)
			speed <= speed - 8'h01;
	end

	assign motor_stopped = (speed == 8'h00);
	assign motor_slow    = (speed < 8'h04);
endmodule

// File: test_servo_stop_select.sv
// Purpose: self-checking bench for the stop selector and overload monitor
// Assumes: inputs driven at the falling edge, outputs sampled there
// Notes:   each stop case restarts the block, since the digits latch once
`timescale 1ns/1ns
module test_servo_stop_select;
	localparam int CL = 64;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic [3:0]  so_d = 4'h0;
	logic [3:0]  g2s_d = 4'h0;
	logic [3:0]  g2m_d = 4'h0;
	logic [1:0]  ctl = 2'h0;
	logic        son = 1'b0;
	logic        a1 = 1'b0;
	logic        a2 = 1'b0;
	logic [15:0] est = 16'h0000;
	logic [15:0] dts = 16'h0000;
	logic [7:0]  warn = 8'h14;
	logic [7:0]  der = 8'h64;
	logic [15:0] ld = 16'h0000;
	logic [15:0] rt = 16'h0100;
	logic        pwr, brk, bta, zsp, tdc, tmd, ow, oc, oi, stopped, slow;
	logic [15:0] dtl, dtm;
	int          n_errors = 0;
	int          total_checks = 0;
	int          cycles = 0;
	int          r;

	servo_stop_select #(.CONT_LIMIT(CL)) u_dut (.clk(clk), .nrst(nrst),
		.servo_off_stop_select(so_d), .group2_stop_select(g2s_d),
		.group2_mode_select(g2m_d), .control_mode(ctl), .servo_on(son),
		.first_group_alarm(a1), .second_group_alarm(a2), .motor_stopped(stopped),
		.motor_slow(slow), .emergency_stop_torque(est), .deceleration_time_setting(dts),
		.overload_warning_percent(warn), .overload_base_current_derating(der),
		.load_current(ld), .rated_current(rt), .power_stage_on(pwr),
		.winding_short_brake(brk), .brake_torque_active(bta), .zero_speed_cmd(zsp),
		.torque_limit_decel(tdc), .time_decel(tmd), .decel_torque_limit(dtl),
		.decel_time(dtm), .overload_warning(ow), .overload_alarm_cont(oc),
		.overload_alarm_inst(oi));

	motor_model u_motor (.clk(clk), .nrst(nrst), .power_stage_on(pwr),
		.winding_short_brake(brk), .slowing(zsp | tdc | tmd),
		.motor_stopped(stopped), .motor_slow(slow));

	always #4 clk = ~clk;

	// ==========================================================
	// checking helpers
	// ==========================================================
	task summarize;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			$display("Error at %0t: run too long", $time);
			summarize;
		end
	end

	task cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	task chk_bit(input logic got, input logic exp, input string what);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: %s got %b want %b", $time, what, got, exp);
		end
	endtask

	task chk_word(input logic [15:0] got, input logic [15:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask

	task chk_win(input int got, input int lo, input int hi, input string what);
		total_checks++;
		if (got < lo || got > hi) begin
			n_errors++;
			$display("Error at %0t: %s at %0d not in %0d..%0d", $time, what, got, lo, hi);
		end
	endtask

	function automatic logic pick(input int which);
		pick = (which == 0) ? pwr : (which == 1) ? stopped : slow;
	endfunction

	task automatic wait_sig(input int which, input logic lvl, input int lim);
		for (int i = 0; i < lim && pick(which) !== lvl; i++)
			cyc(1);
		chk_bit(pick(which), lvl, "wait");
	endtask

	// bits: brake, zero speed, torque decel, timed decel, brake after stop
	function automatic logic [4:0] plan(input logic [3:0] so, g2s, g2m,
			input logic [1:0] md, input int ev);
		logic so0;
		logic h0;
		so0 = (so != 4'h1) && (so != 4'h2);
		// zero-speed and stop-digit group2 paths hold the brake afterwards only for digit 0 itself
		h0  = (so == 4'h0);
		plan = {so != 4'h2, 3'b000, so0};
		if (ev == 2 && md != stop_sel_pkg::MODE_TORQUE) begin
			if (g2m == stop_sel_pkg::G2M_ZERO_SPEED)
				plan = {4'b0100, h0};
			else if (g2m == stop_sel_pkg::G2M_BY_STOP_DIGIT && g2s >= 4'h1 && g2s <= 4'h4)
				plan = {2'b00, g2s < 4'h3, g2s > 4'h2, h0 && g2s[0]};
		end
	endfunction

	// ==========================================================
	// scenarios
	// ==========================================================
	task automatic run_case(input logic [3:0] so, g2s, g2m, input logic [1:0] md,
			input int ev);
		logic [4:0] p;
		p = plan(so, g2s, g2m, md, ev);
		{so_d, g2s_d, g2m_d, ctl, son, a1, a2} = {so, g2s, g2m, md, 3'b000};
		nrst = 1'b0;
		cyc(5);
		nrst = 1'b1;
		cyc(1);
		// digits moved after capture must have no effect
		{so_d, g2s_d, g2m_d} = 12'($urandom);
		son = 1'b1;
		wait_sig(0, 1'b1, 20);
		wait_sig(2, 1'b0, 60);
		cyc(12);
		{est, dts} = $urandom;
		if (ev == 0)
			son = 1'b0;
		else if (ev == 1)
			a1 = 1'b1;
		else
			a2 = 1'b1;
		cyc(2);
		chk_bit(brk, p[4], "brake");
		chk_bit(bta, p[4], "brake torque");
		chk_bit(zsp, p[3], "zero speed");
		chk_bit(tdc, p[2], "torque decel");
		chk_bit(tmd, p[1], "timed decel");
		chk_bit(pwr, |p[3:1], "power");
		chk_word(dtl, p[2] ? est : 16'h0000, "torque limit");
		chk_word(dtm, p[1] ? dts : 16'h0000, "decel time");
		wait_sig(1, 1'b1, 200);
		cyc(2);
		chk_bit(brk, p[0], "post brake");
		chk_bit(pwr, 1'b0, "post power");
		chk_bit(bta, 1'b0, "slow brake torque");
		{son, a1, a2} = 3'b100;
		cyc(2);
		chk_bit(pwr, 1'b1, "restart");
	endtask

	task automatic ovl(input logic [7:0] dr, wp, input logic [15:0] l, rr,
			input int kw, ka);
		int tw;
		int ta;
		{der, warn, ld, rt, tw, ta} = {dr, wp, l, rr, -32'sd1, -32'sd1};
		nrst = 1'b0;
		cyc(5);
		nrst = 1'b1;
		for (int i = 0; i < CL + 12; i++) begin
			cyc(1);
			if (tw < 0 && ow === 1'b1)
				tw = i;
			if (ta < 0 && oc === 1'b1)
				ta = i;
		end
		chk_win(tw, kw < 0 ? -1 : kw - 1, kw < 0 ? -1 : kw + 4, "warning");
		chk_win(ta, ka < 0 ? -1 : ka - 1, ka < 0 ? -1 : ka + 4, "alarm");
		chk_bit(oi, l >= 3 * rr, "instant");
	endtask

	initial begin
		void'($urandom(61));
		for (int s = 1; s <= 4; s++)
			run_case(4'h0, 4'(s), stop_sel_pkg::G2M_BY_STOP_DIGIT,
				stop_sel_pkg::MODE_SPEED, 2);
		for (int s = 0; s <= 2; s++)
			run_case(4'(s), 4'h1, 4'(s), stop_sel_pkg::MODE_POSITION, 2);
		run_case(4'h1, 4'h1, stop_sel_pkg::G2M_BY_STOP_DIGIT,
			stop_sel_pkg::MODE_TORQUE, 2);
		for (int s = 0; s <= 2; s++)
			run_case(4'(s), 4'h0, 4'h0, stop_sel_pkg::MODE_POSITION, s % 2);
		repeat (24)
			run_case(4'($urandom % 4), 4'($urandom % 5), 4'($urandom % 3),
				2'($urandom % 3), $urandom % 3);
		r = 200 + $urandom % 800;
		ovl(8'h64, 8'h32, 16'(3 * r - 1), 16'(r), 32, CL);
		ovl(8'h64, 8'h14, 16'(3 * r), 16'(r), 13, CL);
		ovl(8'h32, 8'h14, 16'(r * 6 / 10 + 1), 16'(r), 13, CL);
		ovl(8'h64, 8'h14, 16'(r * 6 / 10 + 1), 16'(r), -1, -1);
		summarize;
	end
endmodule
